// [rdp_regs.svh]
// Constants of the palette DAC host port and video sync control.
// Assumes inclusion by bare name from the package and the design module.
//
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`ifndef RDP_REGS_SVH
`define RDP_REGS_SVH

// Pipeline depth from pixel capture to DAC codes
`define RDP_PIPE_STAGES   3
// Host bus configurations
`define RDP_MODE_W10      2'h0
`define RDP_MODE_W8P2     2'h1
`define RDP_MODE_W8       2'h2
// DAC code at the blanking level
`define RDP_BLANK_CODE    10'h000
// Reset values
`define RDP_RST_WORD      10'h000
`define RDP_RST_RGB       30'h00000000
`define RDP_RST_CMD       2'h0

`endif

// [rdp_pkg.sv]
// Types shared by the palette DAC host port and sync control.
// Assumes rdp_regs.svh is reachable on the include path.
`include "rdp_regs.svh"

package rdp_pkg;

    // Host port transfer state
    typedef enum logic {
        RDP_IDLE,
        RDP_ACTIVE
    } rdp_state_t;

    // One pixel pipeline stage
    typedef struct packed {
        logic [29:0] rgb;
        logic        blank;
        logic        sync;
    } rdp_pix_t;

    // Latched operation from chip enable fall
    typedef struct packed {
        logic [1:0] cmd;
        logic       rnw;
    } rdp_op_t;

endpackage : rdp_pkg

// [rdp_host_sync.sv]
// Host microprocessor port and composite blank/sync handling.
// Assumes all inputs synchronous to sys_clk; the register file and
// palette sit outside and answer rd_req on the following cycle.
`timescale 1ns/100ps
`include "rdp_regs.svh"

module rdp_host_sync (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce_n,
    input  wire logic        rd_wr_n,
    input  wire logic [1:0]  command_select,
    input  wire logic [9:0]  host_databus_in,
    output logic      [9:0]  host_databus_out,
    output logic             host_databus_oe,
    input  wire logic [1:0]  bus_mode,
    output logic             wr_valid,
    output logic      [1:0]  wr_cmd,
    output logic      [9:0]  wr_data,
    output logic             rd_req,
    output logic      [1:0]  rd_cmd,
    input  wire logic [9:0]  rd_data,
    input  wire logic        pixel_load_strobe,
    input  wire logic [29:0] pixel_rgb_in,
    input  wire logic        composite_blank,
    input  wire logic        composite_sync,
    input  wire logic        sync_decode_enable,
    output logic      [29:0] dac_rgb,
    output logic             dac_blank,
    output logic             green_current_out,
    output logic             sync_delayed_out
);

    // ------------------------------------------------------------------
    // Host port
    // ------------------------------------------------------------------
    rdp_pkg::rdp_state_t state_ff;
    rdp_pkg::rdp_state_t nxt_state;
    rdp_pkg::rdp_op_t    op_ff;
    logic                ce_n_ff;
    logic [9:0]          hold_ff;
    logic [7:0]          low_ff;
    logic                phase_ff;
    logic                rd_pend_ff;
    logic [9:0]          rd_word_ff;

    // Edge detection on chip enable
    wire ce_fall = ce_n_ff & ~ce_n;
    wire is_active = (state_ff == rdp_pkg::RDP_ACTIVE);
    wire ce_rise = ~ce_n_ff & ce_n & is_active;
    wire is_write = ce_rise & ~op_ff.rnw;
    wire is_split = (bus_mode == `RDP_MODE_W8P2);
    wire is_w8    = (bus_mode == `RDP_MODE_W8);

    // Assembled write word per bus configuration
    wire [9:0] wr_word = is_split ? {hold_ff[1:0], low_ff} :
                         is_w8    ? {hold_ff[7:0], 2'h0}   :
                                    hold_ff;
    // Split mode only completes on the second byte
    wire wr_done = is_write & (~is_split | phase_ff);
    wire rd_go   = ce_fall & rd_wr_n;
    // Read word fetched once per split pair
    wire rd_fetch = rd_go & (~is_split | ~phase_ff);

    // Read lane selection per bus configuration
    wire [9:0] rd_lane = is_split ? (phase_ff ? {8'h00, rd_word_ff[9:8]}
                                              : {2'h0, rd_word_ff[7:0]}) :
                         is_w8    ? {2'h0, rd_word_ff[9:2]} :
                                    rd_word_ff;
    // Drive only in a read with enable low, released otherwise
    wire drive = ~ce_n & rd_wr_n & (is_active | ce_fall);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rdp_pkg::RDP_IDLE:   if (ce_fall) nxt_state = rdp_pkg::RDP_ACTIVE;
            rdp_pkg::RDP_ACTIVE: if (ce_n) nxt_state = rdp_pkg::RDP_IDLE;
        endcase
    end

    // Operation decode latched at enable fall
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_ff <= rdp_pkg::RDP_IDLE;
            ce_n_ff  <= 1'b1;
            op_ff    <= '0;
        end else begin
            state_ff <= nxt_state;
            ce_n_ff  <= ce_n;
            if (ce_fall)
                op_ff <= '{cmd: command_select, rnw: rd_wr_n};
        end
    end

    // Bus contents tracked while enable is low; last value wins at rise
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hold_ff <= `RDP_RST_WORD;
            low_ff  <= 8'h00;
        end else begin
            if (~ce_n)
                hold_ff <= host_databus_in;
            if (is_write & is_split & ~phase_ff)
                low_ff <= hold_ff[7:0];
        end
    end

    // Byte phase for split transfers; any mode change restarts it
    always_ff @(posedge sys_clk) begin
        if (rst)
            phase_ff <= 1'b0;
        else if (~is_split)
            phase_ff <= 1'b0;
        else if (ce_rise)
            phase_ff <= ~phase_ff;
    end

    // Write strobe and read request towards the register file
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_valid <= 1'b0;
            wr_cmd   <= `RDP_RST_CMD;
            wr_data  <= `RDP_RST_WORD;
            rd_req   <= 1'b0;
            rd_cmd   <= `RDP_RST_CMD;
        end else begin
            wr_valid <= wr_done;
            if (wr_done) begin
                wr_cmd  <= op_ff.cmd;
                wr_data <= wr_word;
            end
            rd_req <= rd_fetch;
            if (rd_fetch)
                rd_cmd <= command_select;
        end
    end

    // Read word captured one cycle after the request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_pend_ff <= 1'b0;
            rd_word_ff <= `RDP_RST_WORD;
        end else begin
            rd_pend_ff <= rd_req;
            if (rd_pend_ff)
                rd_word_ff <= rd_data;
        end
    end

    // Shared bus driver; data lags the enable, host samples late
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            host_databus_oe  <= 1'b0;
            host_databus_out <= `RDP_RST_WORD;
        end else begin
            host_databus_oe  <= drive;
            host_databus_out <= rd_lane;
        end
    end

    // ------------------------------------------------------------------
    // Pixel pipeline, blank and sync
    // ------------------------------------------------------------------
    rdp_pkg::rdp_pix_t pipe_ff [`RDP_PIPE_STAGES];
    logic              ld_ff;
    wire               ld_rise = pixel_load_strobe & ~ld_ff;
    wire rdp_pkg::rdp_pix_t last = pipe_ff[`RDP_PIPE_STAGES-1];

    // Capture stage on load strobe rise; blank and sync travel together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ld_ff      <= 1'b0;
            pipe_ff[0] <= '0;
        end else begin
            ld_ff <= pixel_load_strobe;
            if (ld_rise)
                pipe_ff[0] <= '{rgb: pixel_rgb_in, blank: composite_blank,
                                sync: composite_sync};
        end
    end

    // Later stages advance every clock so delay stays fixed
    genvar gi;
    generate
        for (gi = 1; gi < `RDP_PIPE_STAGES; gi++) begin : g_pipe
            always_ff @(posedge sys_clk) begin
                if (rst)
                    pipe_ff[gi] <= '0;
                else
                    pipe_ff[gi] <= pipe_ff[gi-1];
            end
        end
    endgenerate

    // Sync is not gated by blank; the timing source keeps it inside
    wire green_sync = last.sync & sync_decode_enable;

    // Output stage: blank overrides colour, sync copied out in step
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            dac_rgb           <= `RDP_RST_RGB;
            dac_blank         <= 1'b1;
            green_current_out <= 1'b0;
            sync_delayed_out  <= 1'b0;
        end else begin
            dac_rgb           <= last.blank ? {3{`RDP_BLANK_CODE}}
                                            : last.rgb;
            dac_blank         <= last.blank;
            green_current_out <= green_sync;
            sync_delayed_out  <= last.sync;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // One clock domain; reset silences every check
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    blank_force_a: assert property (
        dac_blank |-> dac_rgb == {3{`RDP_BLANK_CODE}})
        else $error("colour not at blanking level while blanked");

    green_sync_a: assert property (
        green_current_out |-> sync_delayed_out && $past(sync_decode_enable))
        else $error("green sync without delayed sync");

    sync_ignore_a: assert property (
        !$past(sync_decode_enable) |-> !green_current_out)
        else $error("sync decoded while disabled");

    sync_delay_a: assert property (
        sync_delayed_out == $past(pipe_ff[0].sync, `RDP_PIPE_STAGES))
        else $error("sync output delay wrong");

    load_capture_a: assert property (
        ld_rise |=> pipe_ff[0].blank == $past(composite_blank)
                    && pipe_ff[0].sync == $past(composite_sync))
        else $error("load strobe capture missed");

    bus_release_a: assert property (
        host_databus_oe |-> $past(!ce_n && rd_wr_n))
        else $error("bus driven outside a read");

    write_edge_a: assert property (
        wr_valid |-> $past(ce_n) && !$past(ce_n, 2) && !$past(op_ff.rnw))
        else $error("write not on enable rise");

    write_word_a: assert property (
        wr_valid && bus_mode == `RDP_MODE_W10 |-> wr_data == $past(hold_ff))
        else $error("ten-bit write word wrong");

    read_cmd_a: assert property (
        rd_req |-> $past(ce_fall && rd_wr_n)
                   && rd_cmd == $past(command_select))
        else $error("read request or command wrong");

    read_drive_a: assert property (
        $rose(rd_pend_ff) && bus_mode == `RDP_MODE_W10 && !ce_n
        ##1 !ce_n ##1 !ce_n |-> host_databus_out == rd_word_ff)
        else $error("read word not on bus");

    wr_cmd_a: assert property (
        wr_valid |-> wr_cmd == $past(op_ff.cmd))
        else $error("write command not the one latched at enable fall");

    // Strobe widths: a held strobe would repeat a register access
    wr_pulse_a: assert property (
        wr_valid |=> !wr_valid)
        else $error("write strobe longer than one cycle");

    rd_pulse_a: assert property (
        rd_req |=> !rd_req)
        else $error("read request longer than one cycle");

    // The first split byte must only be parked, never written
    split_first_a: assert property (
        is_write && is_split && !phase_ff |=> !wr_valid)
        else $error("split first byte raised a write");

    // A read transfer never turns into a write at its rise
    read_no_write_a: assert property (
        ce_rise && op_ff.rnw |=> !wr_valid)
        else $error("write strobe at the end of a read");

    // Data lags the enable, so only the enable is checked at once
    read_enable_a: assert property (
        ce_fall && rd_wr_n |=> host_databus_oe)
        else $error("bus not driven in a read");

    // Output stage leaves reset one cycle late, hence the guard
    blank_delay_a: assert property (
        !$past(rst) |->
            dac_blank == $past(pipe_ff[0].blank, `RDP_PIPE_STAGES))
        else $error("blank output delay wrong");

    // Main scenarios the bench is expected to reach
    write_seen_c: cover property (wr_valid);
    read_seen_c:  cover property (rd_req ##2 host_databus_oe);
    blank_sync_c: cover property (dac_blank && green_current_out);
    split_pair_c: cover property (is_split && wr_valid);
    sync_off_c:   cover property (last.sync && !sync_decode_enable);

endmodule // rdp_host_sync

// [rdp_regfile_model.sv]
// Register file model standing behind the palette DAC host port.
// Assumes write and read requests from rdp_host_sync on sys_clk.
`timescale 1ns/100ps

module rdp_regfile_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       wr_valid,
    input  wire logic [1:0] wr_cmd,
    input  wire logic [9:0] wr_data,
    input  wire logic       rd_req,
    input  wire logic [1:0] rd_cmd,
    output logic      [9:0] rd_data
);
    logic [9:0] store_ff [4];

    // ------------------------------------------------------------
    // Storage and read answer
    // ------------------------------------------------------------
    // Word shows in the cycle after the request, then inverts every cycle,
    // so a design sampling one cycle late sees its complement instead of a stale match
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data <= 10'h155;
        end else if (rd_req) begin
            rd_data <= store_ff[rd_cmd];
        end else begin
            rd_data <= ~rd_data;
        end
        if (wr_valid) begin
            store_ff[wr_cmd] <= wr_data;
        end
    end
endmodule // rdp_regfile_model

// [ramdac_host_port_and_sync_ctrl_tb.sv]
// Self-checking bench for the host port and blank/sync pipeline.
// Assumes rdp_regs.svh on the include path and a pull-up on the bus.
`timescale 1ns/100ps
`include "rdp_regs.svh"

module ramdac_host_port_and_sync_ctrl_tb;
    logic        sys_clk, rst, ce_n, rd_wr_n, bus_oe, host_en;
    logic [1:0]  command_select, bus_mode, wr_cmd, rd_cmd;
    logic [9:0]  bus_in, bus_out, wr_data, rd_data, host_dat, got;
    logic        wr_valid, rd_req, pixel_load_strobe, composite_blank;
    logic        composite_sync, sync_decode_enable, dac_blank;
    logic        green_current_out, sync_delayed_out;
    logic [29:0] pixel_rgb_in, dac_rgb;
    int          err_count, checks, pulses;
    int          cyc = 0;

    // Bus level: device, else host, else the pull-up
    assign bus_in = bus_oe ? bus_out : (host_en ? host_dat : 10'h3ff);

    rdp_host_sync dut_u (.sys_clk(sys_clk), .rst(rst), .ce_n(ce_n),
        .rd_wr_n(rd_wr_n), .command_select(command_select),
        .host_databus_in(bus_in), .host_databus_out(bus_out),
        .host_databus_oe(bus_oe), .bus_mode(bus_mode),
        .wr_valid(wr_valid), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data(rd_data),
        .pixel_load_strobe(pixel_load_strobe),
        .pixel_rgb_in(pixel_rgb_in), .composite_blank(composite_blank),
        .composite_sync(composite_sync),
        .sync_decode_enable(sync_decode_enable), .dac_rgb(dac_rgb),
        .dac_blank(dac_blank), .green_current_out(green_current_out),
        .sync_delayed_out(sync_delayed_out));

    rdp_regfile_model model_u (.sys_clk(sys_clk), .rst(rst),
        .wr_valid(wr_valid), .wr_cmd(wr_cmd), .wr_data(wr_data),
        .rd_req(rd_req), .rd_cmd(rd_cmd), .rd_data(rd_data));

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Whole run needs well under 1000 cycles; 3000 catches a hang
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count = err_count + 1;
            final_report();
        end
    end

    task automatic chk(input string name, input logic [29:0] exp,
                       input logic [29:0] seen);
        checks = checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Chip enable held low through the whole write; counts pulses
    task automatic host_write(input logic [1:0] cmd, input logic [9:0] d);
        @(posedge sys_clk);
        ce_n <= 1'b0;
        rd_wr_n <= 1'b0;
        command_select <= cmd;
        host_en <= 1'b1;
        host_dat <= d;
        repeat (2) @(posedge sys_clk);
        ce_n <= 1'b1;
        host_en <= 1'b0;
        pulses = 0;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            if (wr_valid === 1'b1) pulses = pulses + 1;
        end
    endtask

    // Reads after the answer latency, then checks the bus is let go
    task automatic host_read(input logic [1:0] cmd);
        @(posedge sys_clk);
        ce_n <= 1'b0;
        rd_wr_n <= 1'b1;
        command_select <= cmd;
        repeat (5) @(posedge sys_clk);
        #1;
        got = bus_in;
        chk("oe in read", 30'h1, {29'h0, bus_oe});
        @(posedge sys_clk);
        ce_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("oe after read", 30'h0, {29'h0, bus_oe});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every command code written, then all read back, ten-bit bus
    task automatic t_ten_bit;
        for (int i = 0; i < 4; i++) begin
            host_write(i[1:0], 10'h2a5 ^ (10'h0c3 * i[9:0]));
            chk("write pulses", 30'h1, 30'(pulses));
            chk("wr_data", 30'(10'h2a5 ^ (10'h0c3 * i[9:0])),
                30'(wr_data));
            chk("wr_cmd", 30'(i), 30'(wr_cmd));
        end
        for (int i = 0; i < 4; i++) begin
            host_read(i[1:0]);
            chk("read word", 30'(10'h2a5 ^ (10'h0c3 * i[9:0])),
                30'(got));
        end
    endtask

    // Split bytes: no write until the second byte; reads in two halves
    task automatic t_split;
        @(posedge sys_clk);
        bus_mode <= `RDP_MODE_W8P2;
        host_write(2'h2, 10'h396);
        chk("first byte pulses", 30'h0, 30'(pulses));
        host_write(2'h2, 10'h3f1);
        chk("second byte pulses", 30'h1, 30'(pulses));
        chk("split word", 30'h196, 30'(wr_data));
        host_read(2'h2);
        chk("split low", 30'h96, 30'(got[7:0]));
        host_read(2'h2);
        chk("split high", 30'h1, 30'(got[1:0]));
    endtask

    // Eight-bit bus: upper lines ignored on write, word aligned high
    task automatic t_eight;
        @(posedge sys_clk);
        bus_mode <= `RDP_MODE_W8;
        host_write(2'h0, 10'h3c3);
        chk("eight word", 30'h30c, 30'(wr_data));
        host_read(2'h0);
        chk("eight read", 30'hc3, 30'(got[7:0]));
        @(posedge sys_clk);
        bus_mode <= `RDP_MODE_W10;
    endtask

    // One pixel through the pipeline with given blank, sync, enable
    task automatic t_pixel(input logic blank, input logic sync,
                           input logic en, input logic [29:0] rgb);
        @(posedge sys_clk);
        pixel_load_strobe <= 1'b0;
        sync_decode_enable <= en;
        @(posedge sys_clk);
        pixel_load_strobe <= 1'b1;
        composite_blank <= blank;
        composite_sync <= sync;
        pixel_rgb_in <= rgb;
        repeat (`RDP_PIPE_STAGES + 1) @(posedge sys_clk);
        #1;
        chk("dac_blank", 30'(blank), 30'(dac_blank));
        chk("dac_rgb", blank ? {3{`RDP_BLANK_CODE}} : rgb,
            dac_rgb);
        chk("sync out", 30'(sync), 30'(sync_delayed_out));
        chk("green", 30'(sync & en),
            30'(green_current_out));
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        err_count = 0;
        checks = 0;
        rst = 1'b1;
        ce_n = 1'b1;
        rd_wr_n = 1'b1;
        command_select = 2'h0;
        bus_mode = `RDP_MODE_W10;
        host_en = 1'b0;
        host_dat = 10'h000;
        pixel_load_strobe = 1'b0;
        pixel_rgb_in = 30'h00000000;
        composite_blank = 1'b1;
        composite_sync = 1'b0;
        sync_decode_enable = 1'b0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_ten_bit();
        t_split();
        t_eight();
        t_pixel(1'b0, 1'b0, 1'b1, 30'h2a5c3f1e);
        t_pixel(1'b1, 1'b1, 1'b1, 30'h155aa3c3);
        t_pixel(1'b1, 1'b1, 1'b0, 30'h0f0f0f0f);
        t_pixel(1'b1, 1'b0, 1'b1, 30'h3fffffff);
        final_report();
    end
endmodule // ramdac_host_port_and_sync_ctrl_tb
